// >>> rtl/frontend_config_pkg.sv
// Package of offsets, field positions, reset values and carriers for the front-end configuration bank.
`default_nettype none
package frontend_config_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] IO_AND_FILTER_CONFIG_OFS = 8'h0C;
    localparam logic [7:0] FIRST_GAIN_LOOP_CONTROL_OFS = 8'h0D;
    localparam logic [7:0] TIMING_LOOP_COEFFICIENTS_OFS = 8'h0E;
    localparam logic [7:0] FIRST_GAIN_LOOP_REFERENCE_OFS = 8'h0F;
    localparam logic [7:0] SECOND_GAIN_LOOP_CONTROL_OFS = 8'h10;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] IO_AND_FILTER_CONFIG_RST = 8'hF0;
    localparam logic [7:0] FIRST_GAIN_LOOP_CONTROL_RST = 8'h81;
    localparam logic [7:0] TIMING_LOOP_COEFFICIENTS_RST = 8'h23;
    localparam logic [7:0] FIRST_GAIN_LOOP_REFERENCE_RST = 8'h54;
    localparam logic [7:0] SECOND_GAIN_LOOP_CONTROL_RST = 8'h74;
    // ------------------------------------------------------------
    // Field positions and write masks
    // ------------------------------------------------------------
    localparam int OUT_B_OD_BIT = 7;
    localparam int OUT_B_VAL_BIT = 6;
    localparam int OUT_A_OD_BIT = 5;
    localparam int OUT_A_VAL_BIT = 4;
    localparam int FILTER_LSB = 1;
    localparam int Q_INVERT_BIT = 0;
    localparam int DC_COMP_BIT = 7;
    localparam int GAIN_INVERT_BIT = 7;
    localparam int COEFF_LSB = 0;
    localparam int TMG_ALPHA_LSB = 4;
    localparam int TARGET1_LSB = 0;
    localparam int COEFF2_LSB = 5;
    localparam int TARGET2_LSB = 0;
    localparam logic [7:0] IO_CFG_WMASK = 8'hF7;
    localparam logic [7:0] GAIN1_CTL_WMASK = 8'h87;
    localparam logic [7:0] TMG_WMASK = 8'h77;
    localparam logic [7:0] GAIN1_REF_WMASK = 8'hBF;
    // ------------------------------------------------------------
    // Roll-off codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ROLLOFF_35 = 2'h0,
        ROLLOFF_20 = 2'h1
    } rolloff_t;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic [1:0] rolloff;
        logic dc_comp_en;
        logic [2:0] first_gain_loop_coeff;
        logic [5:0] first_gain_target;
        logic [2:0] timing_alpha;
        logic [2:0] timing_beta;
        logic [2:0] second_gain_coeff;
        logic [4:0] second_gain_target;
    } frontend_cfg_t;
endpackage
`default_nettype wire

// >>> rtl/pin_driver.sv
// Output stage for one general-purpose pin with push-pull or open-drain drive.
`default_nettype none
module pin_driver (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // Configuration
    input wire logic i_open_drain,
    input wire logic i_value,
    // Pin
    output logic o_pin_out,
    output logic o_pin_oe
);
    logic out_next;
    logic oe_next;

    // Open drain only pulls low; a high level is left to the external pull-up.
    always_comb begin
        out_next = i_value;
        oe_next = i_open_drain ? ~i_value : 1'b1;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_pin_out <= 1'b1;
            o_pin_oe <= 1'b0;
        end else begin
            o_pin_out <= out_next;
            o_pin_oe <= oe_next;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/frontend_config_registers.sv
// Front-end configuration register bank with output pins, Q negation and gain polarity.
//
// Function
// - Output B: open-drain when set, drives value
// - Output A: open-drain when set, drives value
// - Filter code selects 35 or 20 percent
// - Inversion bit negates every Q sample
// - Q negation applied after the derotator
// - Control top bit enables DC compensation
// - Polarity bit complements first gain output
// - First loop uses six-bit reference
`default_nettype none
module frontend_config_registers
    import frontend_config_pkg::*;
#(
    parameter int SAMPLE_W = 6,
    parameter int GAIN_W = 8
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // Register port from the serial bus slave
    input wire reg_req_t i_req,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    // Derotated sample stream
    input wire logic i_smp_valid,
    input wire logic [SAMPLE_W-1:0] i_derot_i,
    input wire logic [SAMPLE_W-1:0] i_derot_q,
    output logic o_smp_valid,
    output logic [SAMPLE_W-1:0] o_i,
    output logic [SAMPLE_W-1:0] o_q,
    // First gain loop control value
    input wire logic [GAIN_W-1:0] i_gain_ctl,
    output logic [GAIN_W-1:0] o_gain_ctl,
    // Configuration to datapaths
    output frontend_cfg_t o_cfg,
    // General-purpose pins
    output logic o_general_output_a,
    output logic o_general_output_a_oe,
    output logic o_general_output_b,
    output logic o_general_output_b_oe
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (SAMPLE_W < 2 || GAIN_W < 1) begin : g_bad_width
        $error("Sample or gain width too small.");
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] io_and_filter_config_reg, io_and_filter_config_next;
    logic [7:0] first_gain_loop_control_reg, first_gain_loop_control_next;
    logic [7:0] timing_loop_coefficients_reg, timing_loop_coefficients_next;
    logic [7:0] first_gain_loop_reference_reg, first_gain_loop_reference_next;
    logic [7:0] second_gain_loop_control_reg, second_gain_loop_control_next;
    logic [7:0] rdata_next;
    logic rvalid_next;

    // Reserved bits are masked on write so they read zero once written, even if the host slips; reset sets reserved bit 6 of the first gain loop reference.
    always_comb begin
        io_and_filter_config_next = io_and_filter_config_reg;
        first_gain_loop_control_next = first_gain_loop_control_reg;
        timing_loop_coefficients_next = timing_loop_coefficients_reg;
        first_gain_loop_reference_next = first_gain_loop_reference_reg;
        second_gain_loop_control_next = second_gain_loop_control_reg;
        if (i_req.wr) begin
            case (i_req.addr)
                IO_AND_FILTER_CONFIG_OFS: io_and_filter_config_next = i_req.wdata & IO_CFG_WMASK;
                FIRST_GAIN_LOOP_CONTROL_OFS: first_gain_loop_control_next = i_req.wdata & GAIN1_CTL_WMASK;
                TIMING_LOOP_COEFFICIENTS_OFS: timing_loop_coefficients_next = i_req.wdata & TMG_WMASK;
                FIRST_GAIN_LOOP_REFERENCE_OFS: first_gain_loop_reference_next = i_req.wdata & GAIN1_REF_WMASK;
                SECOND_GAIN_LOOP_CONTROL_OFS: second_gain_loop_control_next = i_req.wdata;
                default: ;
            endcase
        end
        rvalid_next = i_req.rd;
        case (i_req.addr)
            IO_AND_FILTER_CONFIG_OFS: rdata_next = io_and_filter_config_reg;
            FIRST_GAIN_LOOP_CONTROL_OFS: rdata_next = first_gain_loop_control_reg;
            TIMING_LOOP_COEFFICIENTS_OFS: rdata_next = timing_loop_coefficients_reg;
            FIRST_GAIN_LOOP_REFERENCE_OFS: rdata_next = first_gain_loop_reference_reg;
            SECOND_GAIN_LOOP_CONTROL_OFS: rdata_next = second_gain_loop_control_reg;
            default: rdata_next = 8'h00;
        endcase
        if (!i_req.rd) begin
            rdata_next = 8'h00;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            io_and_filter_config_reg <= IO_AND_FILTER_CONFIG_RST;
            first_gain_loop_control_reg <= FIRST_GAIN_LOOP_CONTROL_RST;
            timing_loop_coefficients_reg <= TIMING_LOOP_COEFFICIENTS_RST;
            first_gain_loop_reference_reg <= FIRST_GAIN_LOOP_REFERENCE_RST;
            second_gain_loop_control_reg <= SECOND_GAIN_LOOP_CONTROL_RST;
            o_rdata <= 8'h00;
            o_rvalid <= 1'b0;
        end else begin
            io_and_filter_config_reg <= io_and_filter_config_next;
            first_gain_loop_control_reg <= first_gain_loop_control_next;
            timing_loop_coefficients_reg <= timing_loop_coefficients_next;
            first_gain_loop_reference_reg <= first_gain_loop_reference_next;
            second_gain_loop_control_reg <= second_gain_loop_control_next;
            o_rdata <= rdata_next;
            o_rvalid <= rvalid_next;
        end
    end

    // ------------------------------------------------------------
    // Configuration and datapath outputs
    // ------------------------------------------------------------
    frontend_cfg_t cfg_next;
    logic smp_valid_next;
    logic [SAMPLE_W-1:0] i_next;
    logic [SAMPLE_W-1:0] q_next;
    logic [GAIN_W-1:0] gain_next;

    always_comb begin
        cfg_next.rolloff = io_and_filter_config_reg[FILTER_LSB +: 2];
        cfg_next.dc_comp_en = first_gain_loop_control_reg[DC_COMP_BIT];
        cfg_next.first_gain_loop_coeff = first_gain_loop_control_reg[COEFF_LSB +: 3];
        cfg_next.first_gain_target = first_gain_loop_reference_reg[TARGET1_LSB +: 6];
        cfg_next.timing_alpha = timing_loop_coefficients_reg[TMG_ALPHA_LSB +: 3];
        cfg_next.timing_beta = timing_loop_coefficients_reg[COEFF_LSB +: 3];
        cfg_next.second_gain_coeff = second_gain_loop_control_reg[COEFF2_LSB +: 3];
        cfg_next.second_gain_target = second_gain_loop_control_reg[TARGET2_LSB +: 5];
        smp_valid_next = i_smp_valid;
        i_next = i_derot_i;
        // Negation sits after the derotator so the derotator never sees swapped phase.
        q_next = io_and_filter_config_reg[Q_INVERT_BIT] ? SAMPLE_W'(-i_derot_q) : i_derot_q;
        gain_next = first_gain_loop_reference_reg[GAIN_INVERT_BIT] ? ~i_gain_ctl : i_gain_ctl;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_cfg <= '0;
            o_smp_valid <= 1'b0;
            o_i <= '0;
            o_q <= '0;
            o_gain_ctl <= '0;
        end else begin
            o_cfg <= cfg_next;
            o_smp_valid <= smp_valid_next;
            o_i <= i_next;
            o_q <= q_next;
            o_gain_ctl <= gain_next;
        end
    end

    // ------------------------------------------------------------
    // General-purpose pins
    // ------------------------------------------------------------
    pin_driver u_out_a (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_open_drain(io_and_filter_config_reg[OUT_A_OD_BIT]),
        .i_value(io_and_filter_config_reg[OUT_A_VAL_BIT]),
        .o_pin_out(o_general_output_a),
        .o_pin_oe(o_general_output_a_oe)
    );

    pin_driver u_out_b (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_open_drain(io_and_filter_config_reg[OUT_B_OD_BIT]),
        .i_value(io_and_filter_config_reg[OUT_B_VAL_BIT]),
        .o_pin_out(o_general_output_b),
        .o_pin_oe(o_general_output_b_oe)
    );
endmodule
`default_nettype wire

// >>> verification/frontend_config_props.sv
// Checker of the front-end configuration bank as seen at its ports.
`default_nettype none
module frontend_config_props
    import frontend_config_pkg::*;
#(
    parameter int SAMPLE_W = 6,
    parameter int GAIN_W = 8
) (
    // Clock, reset and register port
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire reg_req_t i_req,
    input wire logic [7:0] o_rdata,
    input wire logic o_rvalid,
    // Datapaths
    input wire logic i_smp_valid,
    input wire logic [SAMPLE_W-1:0] i_derot_i,
    input wire logic [SAMPLE_W-1:0] i_derot_q,
    input wire logic o_smp_valid,
    input wire logic [SAMPLE_W-1:0] o_i,
    input wire logic [SAMPLE_W-1:0] o_q,
    input wire logic [GAIN_W-1:0] i_gain_ctl,
    input wire logic [GAIN_W-1:0] o_gain_ctl,
    input wire frontend_cfg_t o_cfg,
    // Pins
    input wire logic o_general_output_a,
    input wire logic o_general_output_a_oe,
    input wire logic o_general_output_b,
    input wire logic o_general_output_b_oe
);
    logic [7:0] wd1_reg, wd2_reg;
    logic q_reg, q_late_reg, g_reg, g_late_reg;
    wire logic w_io = i_req.wr && i_req.addr == IO_AND_FILTER_CONFIG_OFS;
    wire logic w_g1c = i_req.wr && i_req.addr == FIRST_GAIN_LOOP_CONTROL_OFS;
    wire logic w_tmg = i_req.wr && i_req.addr == TIMING_LOOP_COEFFICIENTS_OFS;
    wire logic w_g1r = i_req.wr && i_req.addr == FIRST_GAIN_LOOP_REFERENCE_OFS;
    wire logic w_g2 = i_req.wr && i_req.addr == SECOND_GAIN_LOOP_CONTROL_OFS;
    // Mirrors of the two polarity bits; checks wait until a mirror is steady.
    always_ff @(posedge i_ref_clk) begin
        wd1_reg <= i_req.wdata;
        wd2_reg <= wd1_reg;
        q_late_reg <= q_reg;
        g_late_reg <= g_reg;
        q_reg <= i_srst ? 1'b0 : (w_io ? i_req.wdata[0] : q_reg);
        g_reg <= i_srst ? 1'b0 : (w_g1r ? i_req.wdata[7] : g_reg);
    end
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst);
    AST_PIN_B: assert property (w_io |=> ##1 o_general_output_b == wd2_reg[6] &&
        o_general_output_b_oe == !(wd2_reg[7] && wd2_reg[6])) else $error("pin b drive wrong");
    AST_PIN_A: assert property (w_io |=> ##1 o_general_output_a == wd2_reg[4] &&
        o_general_output_a_oe == !(wd2_reg[5] && wd2_reg[4])) else $error("pin a drive wrong");
    AST_ROLLOFF: assert property (w_io |=> ##1 o_cfg.rolloff == wd2_reg[2:1]) else $error("rolloff wrong");
    AST_Q_NEG: assert property (i_smp_valid && q_reg == q_late_reg |=> o_smp_valid &&
        o_q == (q_late_reg ? SAMPLE_W'(0) - $past(i_derot_q) : $past(i_derot_q))) else $error("q sample wrong");
    AST_GAIN1_CTL: assert property (w_g1c |=> ##1 o_cfg.dc_comp_en == wd2_reg[7] &&
        o_cfg.first_gain_loop_coeff == wd2_reg[2:0]) else $error("gain control fields wrong");
    AST_GAIN_POL: assert property (g_reg == g_late_reg |=>
        o_gain_ctl == (g_late_reg ? ~$past(i_gain_ctl) : $past(i_gain_ctl))) else $error("gain output wrong");
    AST_TARGET1: assert property (w_g1r |=> ##1 o_cfg.first_gain_target == wd2_reg[5:0]) else $error("target wrong");
    AST_TIMING: assert property (w_tmg |=> ##1 o_cfg.timing_alpha == wd2_reg[6:4] &&
        o_cfg.timing_beta == wd2_reg[2:0]) else $error("timing fields wrong");
    AST_GAIN2: assert property (w_g2 |=> ##1 o_cfg.second_gain_coeff == wd2_reg[7:5] &&
        o_cfg.second_gain_target == wd2_reg[4:0]) else $error("second loop fields wrong");
endmodule
bind frontend_config_registers frontend_config_props #(.SAMPLE_W(SAMPLE_W), .GAIN_W(GAIN_W)) u_props (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_req(i_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .i_smp_valid(i_smp_valid), .i_derot_i(i_derot_i), .i_derot_q(i_derot_q), .o_smp_valid(o_smp_valid),
    .o_i(o_i), .o_q(o_q), .i_gain_ctl(i_gain_ctl), .o_gain_ctl(o_gain_ctl), .o_cfg(o_cfg),
    .o_general_output_a(o_general_output_a), .o_general_output_a_oe(o_general_output_a_oe),
    .o_general_output_b(o_general_output_b), .o_general_output_b_oe(o_general_output_b_oe));
`default_nettype wire

// >>> verification/host_model.sv
// Host model that issues register accesses on the strobe port.
`default_nettype none
module host_model
    import frontend_config_pkg::*;
(
    // Clock and answer
    input wire logic i_ref_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    // Request
    output var reg_req_t o_req
);
    timeunit 1ns;
    timeprecision 100ps;
    initial o_req = '0;
    task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        o_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge i_ref_clk);
        o_req <= '0;
    endtask
    // The answer stands for one cycle after the taking edge, so it is read just after it.
    task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
        put(1'b0, a, 8'h00);
        #1;
        d = i_rdata;
        v = i_rvalid;
    endtask
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Testbench for the front-end configuration bank.
`default_nettype none
module tb
    import frontend_config_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_ref_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_smp_valid = 1'b0;
    logic [5:0] i_derot_i = 6'h00, i_derot_q = 6'h00, o_i, o_q;
    logic [7:0] i_gain_ctl = 8'h00, o_gain_ctl, o_rdata, rd;
    logic o_rvalid, o_smp_valid, pa, pa_oe, pb, pb_oe, rv;
    logic [1:0] kb;
    reg_req_t req;
    frontend_cfg_t o_cfg;
    int fails = 0, cmp_count = 0, cycles = 0;
    logic [7:0] ofs [6] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h0B};
    logic [7:0] rst [6] = '{8'hF0, 8'h81, 8'h23, 8'h54, 8'h74, 8'h00};
    logic [7:0] v [5];
    host_model host (.i_ref_clk(i_ref_clk), .i_rdata(o_rdata), .i_rvalid(o_rvalid), .o_req(req));
    frontend_config_registers uut (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_req(req), .o_rdata(o_rdata),
        .o_rvalid(o_rvalid), .i_smp_valid(i_smp_valid), .i_derot_i(i_derot_i), .i_derot_q(i_derot_q),
        .o_smp_valid(o_smp_valid), .o_i(o_i), .o_q(o_q), .i_gain_ctl(i_gain_ctl), .o_gain_ctl(o_gain_ctl),
        .o_cfg(o_cfg), .o_general_output_a(pa), .o_general_output_a_oe(pa_oe), .o_general_output_b(pb),
        .o_general_output_b_oe(pb_oe));
    always #12.5 i_ref_clk = ~i_ref_clk;
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // The whole run needs about 120 cycles, so a hang is cut off well above that.
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(posedge i_ref_clk);
        i_srst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            host.read(ofs[i], rd, rv);
            check("reset value", {rv, rd}, {1'b1, rst[i]});
        end
        check("pins", {pa, pa_oe, pb, pb_oe}, 4'h0A);
        for (int k = 0; k < 4; k++) begin
            kb = 2'(k);
            v = '{{kb, kb, 2'b00, kb[0], kb[1]}, {kb[0], 4'h0, 3'(k + 1)}, {1'b0, 3'(k), 1'b0, 3'(7 - k)},
                {kb[1], 1'b0, 6'(9 * k)}, {3'(k + 4), 5'(7 * k)}};
            for (int i = 0; i < 5; i++) begin
                host.put(1'b1, ofs[i], v[i]);
            end
            for (int i = 0; i < 5; i++) begin
                host.read(ofs[i], rd, rv);
                check("readback", {rv, rd}, {1'b1, v[i]});
            end
            @(posedge i_ref_clk);
            i_smp_valid <= 1'b1;
            i_derot_i <= 6'h0A;
            i_derot_q <= 6'h05;
            i_gain_ctl <= 8'h3C;
            @(posedge i_ref_clk);
            #1;
            check("samples", {o_smp_valid, o_i, o_q}, {1'b1, 6'h0A, kb[1] ? 6'h3B : 6'h05});
            check("gain", o_gain_ctl, kb[1] ? 8'hC3 : 8'h3C);
            check("pins", {pa, pa_oe, pb, pb_oe}, {2{kb[0], !(kb[1] && kb[0])}});
            check("config", o_cfg, {2'(kb[0]), kb[0], 3'(k + 1), 6'(9 * k), 3'(k), 3'(7 - k), 3'(k + 4),
                5'(7 * k)});
        end
        // A reset in mid-run must bring every written register back to its reset value.
        @(posedge i_ref_clk);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_srst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            host.read(ofs[i], rd, rv);
            check("value after reset", {rv, rd}, {1'b1, rst[i]});
        end
        check("pins after reset", {pa, pa_oe, pb, pb_oe}, 4'h0A);
        check("gain after reset", o_gain_ctl, 8'h3C);
        report_and_stop();
    end
endmodule
`default_nettype wire
